// file: rtl/pss_consts.svh
// Constant macros for the parameter set sequencer
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// Word indices of the engine registers on the link
`define PSS_IDX_ENABLE 7'h00
`define PSS_IDX_CLKGATE 7'h01
`define PSS_IDX_SRESET 7'h02
`define PSS_IDX_LOOPS 7'h03
`define PSS_IDX_RANGE 7'h04
`define PSS_IDX_ADCSHARE 7'h05
`define PSS_IDX_CPUKICK 7'h06
`define PSS_IDX_DMAKICK 7'h07
`define PSS_IDX_STATUS 7'h08
`define PSS_IDX_LOOPSDONE 7'h09
`define PSS_IDX_SIG_BASE 7'h10
`define PSS_IDX_PMEM_BASE 7'h40

// Three-bit safety codes
`define PSS_CODE_ON 3'h7
`define PSS_CODE_OFF 3'h0

// Loop count specials
`define PSS_LOOPS_OFF 12'h000
`define PSS_LOOPS_INF 12'hfff

// Trigger select codes
`define PSS_TRIG_NOW 3'h0
`define PSS_TRIG_CPU 3'h1
`define PSS_TRIG_PING 3'h2
`define PSS_TRIG_DMA 3'h3

// Fields of parameter word 0 and of the range register
`define PSS_F_TRIG 2:0
`define PSS_F_SRC 7:4
`define PSS_F_FIRST 3:0
`define PSS_F_LAST 7:4

// Reset values
`define PSS_RST_WORD 16'h0000
`define PSS_RST_LOOPS 12'h000

`endif

// file: rtl/pss_ctrl.sv
// Controller end: APB slave and DMA kick port onto the link
`include "pss_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pss_ctrl
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// DMA kick writes
	input wire logic dma_valid,
	input wire logic [15:0] dma_data,
	output logic dma_ready,
	// Processor interrupt
	output logic sequence_complete_irq,
	// Link to the engine
	pss_link.ctrl lk
);
	import pss_pkg::*;

	pss_ctrl_s r; // Current state
	pss_ctrl_s next_r; // Next state
	logic apb_go; // Fresh APB access waiting

	// Access phase not yet answered
	assign apb_go = psel && penable && !r.pready;
	// DMA waits while software has the link
	assign dma_ready = (r.state == PSS_C_IDLE) && !apb_go;

	// Next-state logic
	always_comb
	begin
		next_r = r;
		next_r.req = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		unique case (r.state)
			PSS_C_IDLE:
			begin
				if (apb_go)
				begin
					// Forward the software access
					next_r.req = 1'b1;
					// Out-of-range address: write is dropped
					next_r.wr = pwrite && (paddr[31:9] == 23'h0);
					next_r.addr = paddr[8:2];
					next_r.wdata = pwdata[15:0];
					next_r.state = PSS_C_APB;
				end
				else if (dma_valid)
				begin
					// One-hot value into the kick flags
					next_r.req = 1'b1;
					next_r.wr = 1'b1;
					next_r.addr = `PSS_IDX_DMAKICK;
					next_r.wdata = dma_data;
					next_r.state = PSS_C_DMA;
				end
			end
			PSS_C_APB:
			begin
				// Return the answer to software
				if (lk.reg_ack)
				begin
					next_r.prdata = {16'h0, lk.reg_rdata};
					next_r.pready = 1'b1;
					next_r.pslverr = lk.reg_err || (paddr[31:9] != 23'h0);
					next_r.state = PSS_C_IDLE;
				end
			end
			PSS_C_DMA:
			begin
				// DMA write completes silently
				if (lk.reg_ack)
				begin
					next_r.state = PSS_C_IDLE;
				end
			end
			default:
			begin
				next_r.state = PSS_C_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// Outputs
	assign lk.reg_req = r.req;
	assign lk.reg_wr = r.wr;
	assign lk.reg_addr = r.addr;
	assign lk.reg_wdata = r.wdata;
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign sequence_complete_irq = lk.sequence_complete_irq;

endmodule : pss_ctrl
`default_nettype wire

// file: rtl/pss_engine.sv
// Engine end: registers, parameter memory and set sequencer
//
// Local design decisions: the APB slave port and the register addresses.
`include "pss_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pss_engine
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register link from the controller
	pss_link.engine lk,
	// Ping-pong buffer select from the ADC side
	input wire logic adc_buffer_select,
	// Compute core handshake
	output logic compute_start,
	input wire logic compute_done,
	output logic [63:0] working_params,
	output logic [3:0] active_set,
	output logic engine_enabled
);
	import pss_pkg::*;

	pss_eng_s r; // Current state
	pss_eng_s next_r; // Next state
	logic enabled; // Enable code and clock gate both on
	logic in_reset; // Soft reset held
	logic [15:0] w0; // Word 0 of the current set
	logic trig_hit; // Trigger of the current set seen
	logic last_pass; // Current pass is the final one
	logic [5:0] cur_base; // Memory index of word 0
	logic [6:0] pm_off; // Offset within parameter memory

	// Only the exact code turns the engine on
	assign enabled = (r.enable_code == `PSS_CODE_ON) && r.clock_gate_on;
	assign in_reset = (r.soft_reset_code == `PSS_CODE_ON);
	assign cur_base = {r.cur_set, 2'b00};
	assign w0 = r.pmem[cur_base];
	assign pm_off = lk.reg_addr - `PSS_IDX_PMEM_BASE;
	assign last_pass = (r.loop_count != `PSS_LOOPS_INF)
		&& ((r.loops_done + 12'h001) == r.loop_count);

	// Trigger decode for the set waiting to start
	always_comb
	begin
		trig_hit = 1'b0;
		unique case (w0[`PSS_F_TRIG])
			`PSS_TRIG_NOW:
			begin
				// Start without waiting
				trig_hit = 1'b1;
			end
			`PSS_TRIG_CPU:
			begin
				// Wait while the kick bit is zero
				trig_hit = r.cpu_kick_bit;
			end
			`PSS_TRIG_PING:
			begin
				// Either direction of buffer switch, sharing on
				trig_hit = r.adc_buffer_share_on
					&& (r.pp_s2 != r.pp_s3);
			end
			`PSS_TRIG_DMA:
			begin
				// Selected kick flag
				trig_hit = r.dma_kick_flags[w0[`PSS_F_SRC]];
			end
			default:
			begin
				// Unused codes never trigger
				trig_hit = 1'b0;
			end
		endcase
	end

	// Next-state logic: sequencer first, register writes after
	always_comb
	begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.err = 1'b0;
		next_r.irq = 1'b0;
		next_r.start = 1'b0;
		// Buffer select passes two flops before the edge detector
		next_r.pp_s1 = adc_buffer_select;
		next_r.pp_s2 = r.pp_s1;
		next_r.pp_s3 = r.pp_s2;

		if (in_reset)
		begin
			// Soft reset returns the sequencer to idle
			next_r.state = PSS_IDLE;
			next_r.cpu_kick_bit = 1'b0;
			next_r.dma_kick_flags = `PSS_RST_WORD;
			next_r.loops_done = `PSS_RST_LOOPS;
		end
		else if (!enabled && (r.state != PSS_DONE))
		begin
			// Disabled engine holds still in idle, except a done engine, which stays done
			next_r.state = PSS_IDLE;
		end
		else
		begin
			unique case (r.state)
				PSS_IDLE:
				begin
					// Start a run only with looping enabled
					if (enabled && (r.loop_count != `PSS_LOOPS_OFF))
					begin
						next_r.cur_set = r.first_set_index;
						next_r.loops_done = `PSS_RST_LOOPS;
						next_r.state = PSS_WAIT;
					end
				end
				PSS_WAIT:
				begin
					// Wait for the set's trigger, then load it
					if (trig_hit)
					begin
						for (int i = 0; i < 4; i++)
						begin
							next_r.work[i] = r.pmem[cur_base + 6'(i)];
						end
						next_r.start = 1'b1;
						next_r.state = PSS_RUN;
						if (w0[`PSS_F_TRIG] == `PSS_TRIG_CPU)
						begin
							// Kick bit clears itself when used
							next_r.cpu_kick_bit = 1'b0;
						end
						if (w0[`PSS_F_TRIG] == `PSS_TRIG_DMA)
						begin
							// Later sets need a fresh transfer
							next_r.dma_kick_flags[w0[`PSS_F_SRC]] = 1'b0;
						end
					end
				end
				PSS_RUN:
				begin
					// Compute finished: move on
					if (compute_done)
					begin
						next_r.state = PSS_WAIT;
						next_r.cur_set = r.cur_set + 4'h1;
						if (r.cur_set == r.last_set_index)
						begin
							// End of pass: wrap or finish
							next_r.cur_set = r.first_set_index;
							next_r.loops_done = r.loops_done + 12'h001;
							if (last_pass)
							begin
								next_r.state = PSS_DONE;
								next_r.irq = 1'b1;
							end
						end
					end
				end
				PSS_DONE:
				begin
					// Parked until soft reset
					next_r.state = PSS_DONE;
				end
			endcase
		end

		// Register access from the controller
		if (lk.reg_req)
		begin
			next_r.ack = 1'b1;
			next_r.rdata = `PSS_RST_WORD;
			if (lk.reg_addr >= `PSS_IDX_PMEM_BASE)
			begin
				// Parameter memory, four words per set
				next_r.rdata = r.pmem[pm_off[5:0]];
				if (lk.reg_wr)
				begin
					next_r.pmem[pm_off[5:0]] = lk.reg_wdata;
				end
			end
			else if (lk.reg_addr >= `PSS_IDX_SIG_BASE
				&& lk.reg_addr < `PSS_IDX_SIG_BASE + 7'h10)
			begin
				// Read-only one-hot signatures
				next_r.rdata = 16'h0001 << lk.reg_addr[3:0];
			end
			else
			begin
				unique case (lk.reg_addr)
					`PSS_IDX_ENABLE:
					begin
						next_r.rdata = {13'h0, r.enable_code};
						if (lk.reg_wr)
						begin
							next_r.enable_code = lk.reg_wdata[2:0];
						end
					end
					`PSS_IDX_CLKGATE:
					begin
						next_r.rdata = {15'h0, r.clock_gate_on};
						if (lk.reg_wr)
						begin
							next_r.clock_gate_on = lk.reg_wdata[0];
						end
					end
					`PSS_IDX_SRESET:
					begin
						next_r.rdata = {13'h0, r.soft_reset_code};
						if (lk.reg_wr)
						begin
							next_r.soft_reset_code = lk.reg_wdata[2:0];
						end
					end
					`PSS_IDX_LOOPS:
					begin
						next_r.rdata = {4'h0, r.loop_count};
						if (lk.reg_wr)
						begin
							next_r.loop_count = lk.reg_wdata[11:0];
						end
					end
					`PSS_IDX_RANGE:
					begin
						next_r.rdata = {8'h0, r.last_set_index, r.first_set_index};
						if (lk.reg_wr)
						begin
							next_r.first_set_index = lk.reg_wdata[`PSS_F_FIRST];
							next_r.last_set_index = lk.reg_wdata[`PSS_F_LAST];
						end
					end
					`PSS_IDX_ADCSHARE:
					begin
						next_r.rdata = {15'h0, r.adc_buffer_share_on};
						if (lk.reg_wr)
						begin
							next_r.adc_buffer_share_on = lk.reg_wdata[0];
						end
					end
					`PSS_IDX_CPUKICK:
					begin
						// Writing one sets; the set wins over consumption
						next_r.rdata = {15'h0, r.cpu_kick_bit};
						if (lk.reg_wr && lk.reg_wdata[0])
						begin
							next_r.cpu_kick_bit = 1'b1;
						end
					end
					`PSS_IDX_DMAKICK:
					begin
						// One bits written are ORed in; a new set wins
						next_r.rdata = r.dma_kick_flags;
						if (lk.reg_wr)
						begin
							next_r.dma_kick_flags = next_r.dma_kick_flags
								| lk.reg_wdata;
						end
					end
					`PSS_IDX_STATUS:
					begin
						next_r.rdata = {8'h0, r.cur_set, 2'h0, r.state};
					end
					`PSS_IDX_LOOPSDONE:
					begin
						next_r.rdata = {4'h0, r.loops_done};
					end
					default:
					begin
						// Unmapped index reads zero and flags an error
						next_r.err = 1'b1;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// Outputs straight from the state
	assign lk.reg_ack = r.ack;
	assign lk.reg_rdata = r.rdata;
	assign lk.reg_err = r.err;
	assign lk.sequence_complete_irq = r.irq;
	assign compute_start = r.start;
	assign working_params = r.work;
	assign active_set = r.cur_set;
	assign engine_enabled = enabled;

endmodule : pss_engine
`default_nettype wire

// file: rtl/pss_link.sv
// Link between the controller end and the engine end
`timescale 1ns/10ps
`default_nettype none
interface pss_link;
	logic reg_req; // One-cycle register request
	logic reg_wr; // High for write
	logic [6:0] reg_addr; // Word index
	logic [15:0] reg_wdata; // Write data
	logic reg_ack; // One-cycle answer
	logic [15:0] reg_rdata; // Read data, valid with ack
	logic reg_err; // Unmapped index, valid with ack
	logic sequence_complete_irq; // Completion pulse

	// Engine end
	modport engine (input reg_req, reg_wr, reg_addr, reg_wdata,
		output reg_ack, reg_rdata, reg_err, sequence_complete_irq);

	// Controller end
	modport ctrl (output reg_req, reg_wr, reg_addr, reg_wdata,
		input reg_ack, reg_rdata, reg_err, sequence_complete_irq);
endinterface : pss_link
`default_nettype wire

// file: rtl/pss_pkg.sv
// Types shared by both ends of the parameter set sequencer
package pss_pkg;

	// Sequencer states
	typedef enum logic [1:0]
	{
		PSS_IDLE = 2'h0,
		PSS_WAIT = 2'h1,
		PSS_RUN = 2'h2,
		PSS_DONE = 2'h3
	} pss_state_e;

	// Controller states
	typedef enum logic [1:0]
	{
		PSS_C_IDLE = 2'h0,
		PSS_C_APB = 2'h1,
		PSS_C_DMA = 2'h2
	} pss_cstate_e;

	typedef logic [15:0] pss_word_t;

	// Whole state of the engine end
	typedef struct packed
	{
		pss_state_e state;
		logic [2:0] enable_code;
		logic clock_gate_on;
		logic [2:0] soft_reset_code;
		logic [11:0] loop_count;
		logic [3:0] first_set_index;
		logic [3:0] last_set_index;
		logic adc_buffer_share_on;
		logic cpu_kick_bit;
		pss_word_t dma_kick_flags;
		logic [3:0] cur_set;
		logic [11:0] loops_done;
		logic [3:0][15:0] work;
		logic [63:0][15:0] pmem;
		pss_word_t rdata;
		logic ack;
		logic err;
		logic irq;
		logic start;
		logic pp_s1;
		logic pp_s2;
		logic pp_s3;
	} pss_eng_s;

	// Whole state of the controller end
	typedef struct packed
	{
		pss_cstate_e state;
		logic req;
		logic wr;
		logic [6:0] addr;
		pss_word_t wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pss_ctrl_s;

endpackage : pss_pkg

// file: verification/param_set_sequencer_bench.sv
// Self-checking bench joining controller and engine over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module param_set_sequencer_bench;
	import pss_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic dma_valid, dma_ready, irq, adc_sel, cstart, cdone, en, er;
	logic [15:0] dma_data;
	logic [63:0] wpar, got_par;
	logic [3:0] aset, got_set;
	logic [15:0] pm [64]; // Model of the parameter memory
	int failures = 0, n_checks = 0, n_start = 0, n_irq = 0, seed = 89;
	pss_link link();
	pss_ctrl pss_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
		.sequence_complete_irq(irq), .lk(link));
	pss_engine pss_engine_i (.pclk(pclk), .presetn(presetn), .lk(link),
		.adc_buffer_select(adc_sel), .compute_start(cstart),
		.compute_done(cdone), .working_params(wpar), .active_set(aset),
		.engine_enabled(en));
	pss_link_chk pss_link_chk_i (.pclk(pclk), .presetn(presetn),
		.reg_req(link.reg_req), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
		.reg_rdata(link.reg_rdata), .reg_err(link.reg_err),
		.sequence_complete_irq(link.sequence_complete_irq));
	// Clock at 40 MHz
	initial
	begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	// Record every compute start and completion pulse
	always @(posedge pclk)
	begin
		if (cstart === 1'b1)
		begin
			n_start++;
			got_set = aset;
			got_par = wpar;
		end
		if (irq === 1'b1)
			n_irq++;
	end
	// Print counts and verdict, then stop
	task automatic conclude;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	// One APB transfer, waiting for pready
	task automatic apb(input logic w, input logic [6:0] i, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {23'h0, i, 2'b00};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			failures++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One DMA kick write
	task automatic dma(input logic [15:0] v);
		@(posedge pclk);
		dma_valid <= 1'b1;
		dma_data <= v;
		do @(posedge pclk); while (dma_ready !== 1'b1);
		dma_valid <= 1'b0;
	endtask : dma
	// Fire the trigger of set s, then compare the start with the model
	task automatic step(input int s);
		int b, k;
		b = n_start;
		repeat (6) @(posedge pclk);
		case (pm[s*4][2:0])
			3'h1:
			begin
				`CHK(n_start, b)
				apb(1'b1, 7'h06, 16'h0001);
			end
			3'h2:
			begin
				`CHK(n_start, b)
				adc_sel <= ~adc_sel;
			end
			3'h3:
			begin
				dma(16'h0001 << (pm[s*4][7:4] + 4'h1));
				repeat (6) @(posedge pclk);
				`CHK(n_start, b)
				dma(16'h0001 << pm[s*4][7:4]);
			end
			default: ;
		endcase
		k = 0;
		while (n_start == b && k < 100)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 100)
			failures++;
		`CHK(got_set, 4'(s))
		`CHK(got_par, {pm[s*4+3], pm[s*4+2], pm[s*4+1], pm[s*4]})
		repeat (3) @(posedge pclk);
		cdone <= 1'b1;
		@(posedge pclk);
		cdone <= 1'b0;
	endtask : step
	// Program range and loops, enable, run n steps from first
	task automatic run(input int f, input int l, input int lp, input int n);
		int s;
		apb(1'b1, 7'h04, 16'((l << 4) | f));
		apb(1'b1, 7'h03, 16'(lp));
		apb(1'b1, 7'h01, 16'h0001);
		apb(1'b1, 7'h00, 16'h0007);
		s = f;
		repeat (n)
		begin
			step(s);
			s = (s == l) ? f : (s + 1) % 16;
		end
	endtask : run
	// Watchdog
	initial
	begin
		#2000000;
		failures++;
		conclude();
	end
	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, dma_valid, dma_data} = '0;
		{adc_sel, cdone} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(en, 1'b0)
		for (int n = 0; n < 16; n++)
		begin
			apb(1'b0, 7'h10 + 7'(n), 16'h0);
			`CHK(rd, 32'h1 << n)
		end
		apb(1'b1, 7'h12, 16'hffff);
		apb(1'b0, 7'h12, 16'h0);
		`CHK(rd, 32'h4)
		apb(1'b0, 7'h0a, 16'h0);
		`CHK({er, rd}, 33'h100000000)
		for (int i = 0; i < 64; i++)
		begin
			pm[i] = 16'($random(seed));
			apb(1'b1, 7'h40 + 7'(i), pm[i]);
		end
		pm[56][2:0] = 3'h0;
		pm[60][2:0] = 3'h1;
		pm[0][2:0] = 3'h2;
		pm[4] = {pm[4][15:8], 8'h53};
		pm[12][2:0] = 3'h0;
		foreach (pm[i]) if (i % 4 == 0) apb(1'b1, 7'h40 + 7'(i), pm[i]);
		apb(1'b1, 7'h05, 16'h0001);
		apb(1'b1, 7'h00, 16'h0006);
		repeat (20) @(posedge pclk);
		`CHK(en, 1'b0)
		`CHK(n_start, 0)
		run(14, 1, 2, 8);
		repeat (4) @(posedge pclk);
		`CHK(n_irq, 1)
		apb(1'b0, 7'h08, 16'h0);
		`CHK(rd[1:0], 2'h3)
		apb(1'b0, 7'h07, 16'h0);
		`CHK(rd[15:0], 16'h0040)
		apb(1'b1, 7'h00, 16'h0000);
		apb(1'b1, 7'h02, 16'h0007);
		apb(1'b1, 7'h02, 16'h0000);
		apb(1'b0, 7'h08, 16'h0);
		`CHK(rd[1:0], 2'h0)
		run(3, 3, 0, 0);
		repeat (20) @(posedge pclk);
		`CHK(n_start, 8)
		apb(1'b1, 7'h00, 16'h0000);
		run(3, 3, 4095, 6);
		repeat (4) @(posedge pclk);
		`CHK(n_irq, 1)
		`CHK(en, 1'b1)
		conclude();
	end
endmodule : param_set_sequencer_bench
`default_nettype wire

// file: verification/pss_link_chk.sv
// Link protocol checker for the parameter set sequencer
`timescale 1ns/10ps
`default_nettype none
module pss_link_chk
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request side of the link
	input wire logic reg_req,
	input wire logic reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	// Answer side of the link
	input wire logic reg_ack,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_err,
	input wire logic sequence_complete_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Every register request is answered one edge later
	a_ack_after_req: assert property (reg_req |=> reg_ack)
		else $error("request not answered");
	a_no_stray_ack: assert property (reg_ack |-> $past(reg_req))
		else $error("answer without request");
	a_req_spacing: assert property (reg_req |=> !reg_req [*2])
		else $error("requests too close");
	// Unmapped control indices are refused, mapped ones are not
	a_err_unmapped: assert property (reg_req && reg_addr[6:3] == 4'h1
		&& reg_addr[2:0] > 3'h1 |=> reg_err)
		else $error("unmapped index accepted");
	a_mapped_ok: assert property (reg_req && reg_addr < 7'h0a |=> !reg_err)
		else $error("mapped index refused");
	// Signature word n holds bit n alone
	a_sig_onehot: assert property (reg_req && !reg_wr && reg_addr[6:4] == 3'h1
		|=> reg_rdata == (16'h0001 << $past(reg_addr[3:0])))
		else $error("signature word wrong");
	// Completion is a lone pulse and never follows reset at once
	a_irq_lone: assert property (sequence_complete_irq
		|=> !sequence_complete_irq [*8])
		else $error("completion repeated");
	a_quiet_start: assert property ($rose(presetn)
		|-> !sequence_complete_irq [*8])
		else $error("completion right after reset");
endmodule : pss_link_chk
`default_nettype wire
